// *** hw/sioc_ports.sv ***
/*
  System I/O control port bank: video page, mode and colour registers,
  floppy drive output register, parallel printer ports, joystick ports and
  memory configuration / NMI enable port, all byte-wide on the host I/O bus.
  Assumes single-cycle read and write strobes on clk from the bus decoder;
  printer status and joystick lines arrive asynchronously from pins.
*/
// Behaviour
// RULE1 - Video page: bits 0-2 display page, 3-5 processor page, 6-7 address mode.
// RULE2 - Drive output: both selects low picks drive 0; bit0 high, bit1 low drive 1.
// RULE3 - Bit 2 low holds floppy controller in reset; bit 3 passes its DMA and interrupt.
// RULE4 - Bit 4 turns drive 0 motor on; bit 5 turns drive 1 motor on.
// RULE5 - Bit 6 drives floppy terminal count; bit 7 does nothing.
// RULE6 - Software only writes the drive output register; nothing readable there.
// RULE7 - Video mode bits 0-5: hi-res clock, graphics, mono, enable, 640 dot, blink.
// RULE8 - Colour select: background BGRI bits 0-3, foreground intensity 4, colour set 5.
// RULE9 - Printer control bits 0-3 drive active-low lines; bit 5 low enables data drivers.
// RULE10 - Printer control bit 4 lets the acknowledge interrupt through.
// RULE11 - Printer status read only: 0-2 unused, error 3, ack 6, busy 7, active low.
// RULE12 - Status bit 4 one when printer selected; bit 5 zero at end of paper.
// RULE13 - Joystick read: timing states in bits 0-3, button pairs in bits 4-7.
// RULE14 - Writing either joystick port restarts integrators before position timing.
// RULE15 - Memory port: layout code in bits 0-3, bit 7 enables the NMI.
// RULE16 - Memory port reads have no effect and no data; bits 4-6 ignored.
// RULE17 - Reset clears every writable control register to zero.
// RULE18 - Printer data port latches the whole byte and drives it while enabled.
`timescale 1ns/100ps
module sioc_ports (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Host I/O bus
  input  wire logic [15:0]                ioAddr,
  input  wire logic                       ioWrStb,
  input  wire logic                       ioRdStb,
  input  wire logic [7:0]                 ioWrData,
  output logic      [7:0]                 ioRdData,
  output logic                            ioRdValid,
  // Printer status pins
  input  wire sioc_pkg::sioc_prn_status_t prnStatusPins,
  // Joystick timing and button pins
  input  wire logic [7:0]                 joyPins,
  // Video controller side
  output sioc_pkg::sioc_video_t           videoCtrl,
  // Floppy controller side
  output sioc_pkg::sioc_floppy_t          floppyCtrl,
  // Printer side
  output sioc_pkg::sioc_printer_t         printerCtrl,
  // Joystick integrators
  output logic                            joyRestart,
  // Memory layout and NMI
  output logic      [3:0]                 memoryLayoutCode,
  output logic                            nmiEnable
);
  import sioc_pkg::*;

  typedef struct packed {
    logic [7:0]    videoPage;
    logic [7:0]    videoMode;
    logic [7:0]    videoColour;
    logic [7:0]    floppyOut;
    logic [7:0]    prnData;
    logic [PCTL_WIDTH-1:0] prnCtrl;
    logic [MEM_CODE_W-1:0] memCode;
    logic          nmiEn;
    logic          joyRestart;
    logic [7:0]    rdData;
    logic          rdValid;
    sioc_floppy_t  floppyPins;
    sioc_printer_t printerPins;
  } sioc_state_t;

  sioc_state_t      state_reg;
  sioc_state_t      state_next;
  sioc_prn_status_t prnStatusSync;
  logic [7:0]       joySync;

  // Address decode
  logic hitPage;
  logic hitMode;
  logic hitColour;
  logic hitFloppy;
  logic hitPrnData;
  logic hitPrnStatus;
  logic hitPrnCtrl;
  logic hitJoyRestart;
  logic hitJoyPos;
  logic hitMem;
  logic [7:0] statusByte;
  logic [7:0] rdMux;

  // Pin inputs cross into clk before any logic looks at them
  sioc_sync #(
    .WIDTH($bits(sioc_prn_status_t))
  ) u_prn_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .asyncIn(prnStatusPins),
    .syncOut(prnStatusSync)
  );

  sioc_sync #(
    .WIDTH(8)
  ) u_joy_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .asyncIn(joyPins),
    .syncOut(joySync)
  );

  always_comb begin
    hitPage       = (ioAddr == VIDEO_PAGE_PORT);
    hitMode       = (ioAddr == VIDEO_MODE_PORT);
    hitColour     = (ioAddr == VIDEO_COLOUR_PORT);
    hitFloppy     = (ioAddr == FLOPPY_OUTPUT_PORT);
    hitPrnData    = (ioAddr == PRINTER_DATA_PORT);
    hitPrnStatus  = (ioAddr == PRINTER_STATUS_PORT);
    hitPrnCtrl    = (ioAddr == PRINTER_CTRL_PORT);
    hitJoyRestart = (ioAddr == JOY_RESTART_PORT);
    hitJoyPos     = (ioAddr == JOY_POSITION_PORT);
    hitMem        = (ioAddr == MEM_LAYOUT_NMI_A0) || (ioAddr == MEM_LAYOUT_NMI_A1);
  end

  // Status byte: every flag but "selected" reads zero when active
  always_comb begin
    statusByte      = '0;
    statusByte[2:0] = STATUS_UNUSED; // RULE11
    statusByte[3]   = prnStatusSync.errorN; // RULE11
    statusByte[4]   = prnStatusSync.selected; // RULE12
    statusByte[5]   = prnStatusSync.paperEndN; // RULE12
    statusByte[6]   = prnStatusSync.ackN; // RULE11
    statusByte[7]   = prnStatusSync.busyN; // RULE11
  end

  // Read multiplexer; write-only and unmapped ports float high
  always_comb begin
    rdMux = READ_NO_DATA;
    if (hitPage) begin
      rdMux = state_reg.videoPage;
    end else if (hitMode) begin
      rdMux = state_reg.videoMode;
    end else if (hitColour) begin
      rdMux = state_reg.videoColour;
    end else if (hitPrnData) begin
      rdMux = state_reg.prnData;
    end else if (hitPrnStatus) begin
      rdMux = statusByte;
    end else if (hitPrnCtrl) begin
      rdMux = {2'h0, state_reg.prnCtrl};
    end else if (hitJoyPos) begin
      rdMux = joySync; // RULE13
    end else if (hitFloppy || hitMem) begin
      rdMux = READ_NO_DATA; // RULE6 RULE16
    end
  end

  always_comb begin
    state_next            = state_reg;
    state_next.joyRestart = 1'b0;
    state_next.rdValid    = 1'b0;

    // Writes
    if (ioWrStb) begin
      if (hitPage) begin
        state_next.videoPage = ioWrData; // RULE1
      end
      if (hitMode) begin
        state_next.videoMode = {2'h0, ioWrData[5:0]}; // RULE7
      end
      if (hitColour) begin
        state_next.videoColour = {2'h0, ioWrData[5:0]}; // RULE8
      end
      if (hitFloppy) begin
        state_next.floppyOut = {1'b0, ioWrData[6:0]}; // RULE5
      end
      if (hitPrnData) begin
        state_next.prnData = ioWrData; // RULE18
      end
      if (hitPrnCtrl) begin
        state_next.prnCtrl = ioWrData[PCTL_WIDTH-1:0]; // RULE9 RULE10
      end
      if (hitJoyRestart || hitJoyPos) begin
        state_next.joyRestart = 1'b1; // RULE14
      end
      if (hitMem) begin
        state_next.memCode = ioWrData[MEM_CODE_LSB +: MEM_CODE_W]; // RULE15 RULE16
        state_next.nmiEn   = ioWrData[MEM_NMI_BIT]; // RULE15
      end
    end

    // Reads return data one cycle after the strobe and change nothing else
    if (ioRdStb) begin
      state_next.rdData  = rdMux; // RULE16
      state_next.rdValid = 1'b1;
    end

    // Floppy pins decoded from the register so the outputs are plain flops
    state_next.floppyPins.drive0Select =
      !state_next.floppyOut[DOR_SEL0_BIT] && !state_next.floppyOut[DOR_SEL1_BIT]; // RULE2
    state_next.floppyPins.drive1Select =
      state_next.floppyOut[DOR_SEL0_BIT] && !state_next.floppyOut[DOR_SEL1_BIT]; // RULE2
    state_next.floppyPins.floppyControllerResetN = state_next.floppyOut[DOR_RESETN_BIT]; // RULE3
    state_next.floppyPins.dmaIrqEnable  = state_next.floppyOut[DOR_DMAIRQ_BIT]; // RULE3
    state_next.floppyPins.motor0On      = state_next.floppyOut[DOR_MOTOR0_BIT]; // RULE4
    state_next.floppyPins.motor1On      = state_next.floppyOut[DOR_MOTOR1_BIT]; // RULE4
    state_next.floppyPins.terminalCount = state_next.floppyOut[DOR_TC_BIT]; // RULE5

    // Printer pins; control lines follow the register level directly
    state_next.printerPins.data          = state_next.prnData; // RULE18
    state_next.printerPins.dataOe        = !state_next.prnCtrl[PCTL_OEN_BIT]; // RULE9
    state_next.printerPins.strobeN       = state_next.prnCtrl[PCTL_STROBE_BIT]; // RULE9
    state_next.printerPins.autoLineFeedN = state_next.prnCtrl[PCTL_AUTOLF_BIT]; // RULE9
    state_next.printerPins.initN         = state_next.prnCtrl[PCTL_INIT_BIT]; // RULE9
    state_next.printerPins.selectInN     = state_next.prnCtrl[PCTL_SELIN_BIT]; // RULE9
    // Interrupt request follows acknowledge low only while enabled
    state_next.printerPins.ackIrq =
      state_next.prnCtrl[PCTL_IRQEN_BIT] && !prnStatusSync.ackN; // RULE10
  end

  // Reset leaves motors off, interrupts masked and the floppy controller held in reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg                                    <= '0; // RULE17
      state_reg.videoPage                          <= CTRL_RESET_VALUE;
      state_reg.floppyOut                          <= CTRL_RESET_VALUE;
      state_reg.rdData                             <= READ_NO_DATA;
      state_reg.floppyPins.drive0Select            <= 1'b1;
      state_reg.printerPins.dataOe                 <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs, all straight from state flops
  always_comb begin
    videoCtrl                 = '0;
    videoCtrl.displayPage     = state_reg.videoPage[PAGE_DISPLAY_LSB +: 3]; // RULE1
    videoCtrl.cpuPage         = state_reg.videoPage[PAGE_CPU_LSB +: 3]; // RULE1
    videoCtrl.videoAddrMode   = state_reg.videoPage[PAGE_MODE_LSB +: 2]; // RULE1
    videoCtrl.hiResClock      = state_reg.videoMode[0]; // RULE7
    videoCtrl.graphicsSelect  = state_reg.videoMode[1];
    videoCtrl.blackWhite      = state_reg.videoMode[2];
    videoCtrl.videoEnable     = state_reg.videoMode[3];
    videoCtrl.graphics640     = state_reg.videoMode[4];
    videoCtrl.blinkEnable     = state_reg.videoMode[5];
    videoCtrl.background      = state_reg.videoColour[3:0]; // RULE8
    videoCtrl.fgIntensity     = state_reg.videoColour[4];
    videoCtrl.colourSetSelect = state_reg.videoColour[5];
  end

  assign floppyCtrl       = state_reg.floppyPins;
  assign printerCtrl      = state_reg.printerPins;
  assign joyRestart       = state_reg.joyRestart;
  assign memoryLayoutCode = state_reg.memCode;
  assign nmiEnable        = state_reg.nmiEn;
  assign ioRdData         = state_reg.rdData;
  assign ioRdValid        = state_reg.rdValid;

endmodule

// *** hw/sioc_pkg.sv ***
/*
  Shared constants and carrier types for the system I/O control port bank:
  port addresses, field positions, reset values and the pin-side structs.
  Assumes a byte-wide host I/O bus with a 16-bit port address.
*/
package sioc_pkg;

  // Port addresses on the host I/O bus
  localparam logic [15:0] MEM_LAYOUT_NMI_A0   = 16'h00a0;
  localparam logic [15:0] MEM_LAYOUT_NMI_A1   = 16'h00a1;
  localparam logic [15:0] JOY_RESTART_PORT    = 16'h0200;
  localparam logic [15:0] JOY_POSITION_PORT   = 16'h0201;
  localparam logic [15:0] PRINTER_DATA_PORT   = 16'h0378;
  localparam logic [15:0] PRINTER_STATUS_PORT = 16'h0379;
  localparam logic [15:0] PRINTER_CTRL_PORT   = 16'h037a;
  localparam logic [15:0] VIDEO_MODE_PORT     = 16'h03d8;
  localparam logic [15:0] VIDEO_COLOUR_PORT   = 16'h03d9;
  localparam logic [15:0] VIDEO_PAGE_PORT     = 16'h03df;
  localparam logic [15:0] FLOPPY_OUTPUT_PORT  = 16'h03f2;

  // Reset and fixed read values
  localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_NO_DATA     = 8'hff;
  localparam logic [2:0] STATUS_UNUSED    = 3'h7;

  // Video page register fields
  localparam int PAGE_DISPLAY_LSB = 0;
  localparam int PAGE_CPU_LSB     = 3;
  localparam int PAGE_MODE_LSB    = 6;

  // Floppy drive output register fields
  localparam int DOR_SEL0_BIT    = 0;
  localparam int DOR_SEL1_BIT    = 1;
  localparam int DOR_RESETN_BIT  = 2;
  localparam int DOR_DMAIRQ_BIT  = 3;
  localparam int DOR_MOTOR0_BIT  = 4;
  localparam int DOR_MOTOR1_BIT  = 5;
  localparam int DOR_TC_BIT      = 6;

  // Printer control fields
  localparam int PCTL_STROBE_BIT = 0;
  localparam int PCTL_AUTOLF_BIT = 1;
  localparam int PCTL_INIT_BIT   = 2;
  localparam int PCTL_SELIN_BIT  = 3;
  localparam int PCTL_IRQEN_BIT  = 4;
  localparam int PCTL_OEN_BIT    = 5;
  localparam int PCTL_WIDTH      = 6;

  // Memory configuration fields
  localparam int MEM_CODE_LSB  = 0;
  localparam int MEM_CODE_W    = 4;
  localparam int MEM_NMI_BIT   = 7;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic [1:0] videoAddrMode;
    logic [2:0] cpuPage;
    logic [2:0] displayPage;
    logic       blinkEnable;
    logic       graphics640;
    logic       videoEnable;
    logic       blackWhite;
    logic       graphicsSelect;
    logic       hiResClock;
    logic       colourSetSelect;
    logic       fgIntensity;
    logic [3:0] background;
  } sioc_video_t;

  typedef struct packed {
    logic       drive0Select;
    logic       drive1Select;
    logic       floppyControllerResetN;
    logic       dmaIrqEnable;
    logic       motor0On;
    logic       motor1On;
    logic       terminalCount;
  } sioc_floppy_t;

  typedef struct packed {
    logic [7:0] data;
    logic       dataOe;
    logic       strobeN;
    logic       autoLineFeedN;
    logic       initN;
    logic       selectInN;
    logic       ackIrq;
  } sioc_printer_t;

  typedef struct packed {
    logic busyN;
    logic ackN;
    logic paperEndN;
    logic selected;
    logic errorN;
  } sioc_prn_status_t;

endpackage

// *** hw/sioc_sync.sv ***
/*
  Two-stage level synchroniser, width set by parameter.
  Assumes the input is asynchronous to clk; only the second stage is read.
*/
`timescale 1ns/100ps
module sioc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sioc_sync_state_t;

  sioc_sync_state_t state_reg;
  sioc_sync_state_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stage2;

endmodule

// *** verif/sioc_periph_model.sv ***
/*
  Pin-side model of the printer and the joystick integrators.
  Assumes the bench sets the printer status levels and buttons.
*/
`timescale 1ns/100ps
module sioc_periph_model #(
  parameter int JOY_SPAN = 20
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Bench settings
  input  wire sioc_pkg::sioc_prn_status_t statusLevels,
  input  wire logic [3:0]                 buttons,
  input  wire logic                       joyRestart,
  // Pins toward the port bank
  output sioc_pkg::sioc_prn_status_t      prnStatusPins,
  output logic      [7:0]                 joyPins
);
  import sioc_pkg::*;
  logic [7:0] spanReg;

  // Integrators only run after a restart, so untimed reads see zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spanReg <= 8'h00;
    end else if (joyRestart) begin
      spanReg <= 8'(JOY_SPAN);
    end else if (spanReg != 8'h00) begin
      spanReg <= spanReg - 8'h01;
    end
  end
  assign joyPins       = {buttons, {4{spanReg != 8'h00}}};
  assign prnStatusPins = statusLevels;
endmodule

// *** verif/sioc_ports_sva.sv ***
/*
  Assertions on the port bank, bound to sioc_ports.
  Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/100ps
module sioc_ports_sva (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       arst_n,
  // Host I/O bus
  input wire logic [15:0]                ioAddr,
  input wire logic                       ioWrStb,
  input wire logic                       ioRdStb,
  input wire logic [7:0]                 ioWrData,
  input wire logic [7:0]                 ioRdData,
  input wire logic                       ioRdValid,
  // Outputs
  input wire sioc_pkg::sioc_video_t      videoCtrl,
  input wire sioc_pkg::sioc_floppy_t     floppyCtrl,
  input wire sioc_pkg::sioc_printer_t    printerCtrl,
  input wire logic                       joyRestart,
  input wire logic [3:0]                 memoryLayoutCode,
  input wire logic                       nmiEnable
);
  import sioc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire wrFlop = ioWrStb && ioAddr == FLOPPY_OUTPUT_PORT;
  wire wrCtrl = ioWrStb && ioAddr == PRINTER_CTRL_PORT;
  wire wrData = ioWrStb && ioAddr == PRINTER_DATA_PORT;
  wire wrJoy  = ioWrStb && (ioAddr == JOY_RESTART_PORT || ioAddr == JOY_POSITION_PORT);
  wire isMem  = ioAddr == MEM_LAYOUT_NMI_A0 || ioAddr == MEM_LAYOUT_NMI_A1;

  floppy_noread_a: assert property (ioRdStb && ioAddr == FLOPPY_OUTPUT_PORT |=> ioRdData == READ_NO_DATA)
    else $error("drive output read gave data");
  mem_noread_a: assert property (ioRdStb && isMem |=> ioRdData == READ_NO_DATA && $stable(nmiEnable))
    else $error("memory port read had effect");
  status_read_a: assert property (ioRdStb && ioAddr == PRINTER_STATUS_PORT |=> ioRdValid && ioRdData[2:0] == STATUS_UNUSED)
    else $error("status unused bits wrong");
  page_write_a: assert property (ioWrStb && ioAddr == VIDEO_PAGE_PORT |=>
    {videoCtrl.videoAddrMode, videoCtrl.cpuPage, videoCtrl.displayPage} == $past(ioWrData))
    else $error("page fields wrong");
  colour_write_a: assert property (ioWrStb && ioAddr == VIDEO_COLOUR_PORT |=>
    {videoCtrl.colourSetSelect, videoCtrl.fgIntensity, videoCtrl.background} == $past(ioWrData[5:0]))
    else $error("colour fields wrong");
  drive_select_a: assert property (wrFlop && !ioWrData[1] |=>
    floppyCtrl.drive0Select != $past(ioWrData[0]) && floppyCtrl.drive1Select == $past(ioWrData[0]))
    else $error("drive select wrong");
  floppy_bits_a: assert property (wrFlop |=> {floppyCtrl.terminalCount, floppyCtrl.motor1On, floppyCtrl.motor0On,
    floppyCtrl.dmaIrqEnable, floppyCtrl.floppyControllerResetN} == $past(ioWrData[6:2]))
    else $error("floppy control bits wrong");
  ctrl_lines_a: assert property (wrCtrl |=> printerCtrl.dataOe != $past(ioWrData[5]) && {printerCtrl.selectInN,
    printerCtrl.initN, printerCtrl.autoLineFeedN, printerCtrl.strobeN} == $past(ioWrData[3:0]))
    else $error("printer lines wrong");
  joy_restart_a: assert property (wrJoy |=> joyRestart ##1 (joyRestart == $past(wrJoy)))
    else $error("restart pulse wrong");
  mem_write_a: assert property (ioWrStb && isMem |=>
    memoryLayoutCode == $past(ioWrData[3:0]) && nmiEnable == $past(ioWrData[7]))
    else $error("memory port write wrong");
  data_hold_a: assert property (!wrData |=> $stable(printerCtrl.data))
    else $error("printer data changed");
  cover property (wrFlop);
  cover property (joyRestart);
  cover property (printerCtrl.ackIrq);
endmodule

bind sioc_ports sioc_ports_sva sioc_ports_sva_i (.clk(clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
  .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .videoCtrl(videoCtrl),
  .floppyCtrl(floppyCtrl), .printerCtrl(printerCtrl), .joyRestart(joyRestart),
  .memoryLayoutCode(memoryLayoutCode), .nmiEnable(nmiEnable));

// *** verif/tb_system_io_control_ports.sv ***
/*
  Self-checking bench for the I/O port bank.
  Assumes sioc_ports, the pin model and the bound checker are compiled.
*/
`timescale 1ns/100ps
module tb_system_io_control_ports;
  import sioc_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, ioWrStb = 1'b0, ioRdStb = 1'b0, ioRdValid, joyRestart, nmiEnable;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0]  ioWrData = 8'h00, ioRdData, joyPins;
  logic [3:0]  buttons = 4'h0, memoryLayoutCode;
  sioc_prn_status_t statusLevels = 5'h1f, prnStatusPins;
  sioc_video_t videoCtrl;
  sioc_floppy_t floppyCtrl;
  sioc_printer_t printerCtrl;
  int errors = 0, nCompared = 0;

  always #5 clk = ~clk;
  sioc_ports sioc_ports_i (.clk(clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .prnStatusPins(prnStatusPins),
    .joyPins(joyPins), .videoCtrl(videoCtrl), .floppyCtrl(floppyCtrl), .printerCtrl(printerCtrl),
    .joyRestart(joyRestart), .memoryLayoutCode(memoryLayoutCode), .nmiEnable(nmiEnable));
  sioc_periph_model sioc_periph_model_i (.clk(clk), .arst_n(arst_n), .statusLevels(statusLevels),
    .buttons(buttons), .joyRestart(joyRestart), .prnStatusPins(prnStatusPins), .joyPins(joyPins));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    ioAddr <= a; ioWrData <= d; ioWrStb <= 1'b1;
    @(posedge clk);
    ioWrStb <= 1'b0;
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    ioAddr <= a; ioRdStb <= 1'b1;
    @(posedge clk);
    ioRdStb <= 1'b0;
    #1;
    chk(ioRdValid, 1);
    chk(ioRdData, exp);
  endtask
  task test_done;
    $display("Compared %0d, errors %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset clears controls; drive 0 selected, controller held in reset
  task test_reset;
    chk(videoCtrl, 20'h0);
    chk({floppyCtrl, memoryLayoutCode, nmiEnable, joyRestart}, {7'h40, 6'h0});
    chk({ioRdValid, ioRdData}, 9'h0ff);
    chk(printerCtrl, {8'h00, 6'h20});
  endtask
  task test_video;
    wr(VIDEO_PAGE_PORT, 8'ha5);
    chk(videoCtrl[19:12], 8'ha5);
    wr(VIDEO_MODE_PORT, 8'hd5);
    chk(videoCtrl[11:6], 6'h15);
    wr(VIDEO_COLOUR_PORT, 8'hea);
    chk(videoCtrl[5:0], 6'h2a);
    rd(VIDEO_PAGE_PORT, 8'ha5);
    rd(VIDEO_MODE_PORT, 8'h15);
    rd(VIDEO_COLOUR_PORT, 8'h2a);
  endtask
  task test_floppy;
    wr(FLOPPY_OUTPUT_PORT, 8'h1d);
    chk(floppyCtrl, 7'h3c);
    wr(FLOPPY_OUTPUT_PORT, 8'he4);
    chk(floppyCtrl, 7'h53);
    rd(FLOPPY_OUTPUT_PORT, 8'hff);
  endtask
  task test_printer;
    wr(PRINTER_DATA_PORT, 8'h5a);
    chk(printerCtrl, {8'h5a, 6'h20});
    wr(PRINTER_CTRL_PORT, 8'hee);
    chk(printerCtrl, {8'h5a, 6'h0e});
    rd(PRINTER_CTRL_PORT, 8'h2e);
    rd(PRINTER_DATA_PORT, 8'h5a);
  endtask
  // Pins pass two sync stages, so wait before looking
  task test_status;
    statusLevels <= 5'b10110;
    wr(PRINTER_CTRL_PORT, 8'h10);
    repeat (4) @(posedge clk);
    #1;
    chk(printerCtrl.ackIrq, 1);
    rd(PRINTER_STATUS_PORT, 8'hb7);
    wr(PRINTER_STATUS_PORT, 8'h00);
    statusLevels <= 5'b01001;
    repeat (4) @(posedge clk);
    #1;
    chk(printerCtrl.ackIrq, 0);
    rd(PRINTER_STATUS_PORT, 8'h4f);
  endtask
  task test_joystick;
    buttons <= 4'ha;
    // Buttons need both sync stages before a read can see them
    repeat (2) @(posedge clk);
    rd(JOY_POSITION_PORT, 8'ha0);
    wr(JOY_RESTART_PORT, 8'h00);
    chk(joyRestart, 1);
    @(posedge clk);
    #1;
    chk(joyRestart, 0);
    repeat (3) @(posedge clk);
    rd(JOY_POSITION_PORT, 8'haf);
    repeat (25) @(posedge clk);
    rd(JOY_POSITION_PORT, 8'ha0);
    wr(JOY_POSITION_PORT, 8'h55);
    chk(joyRestart, 1);
  endtask
  task test_memory;
    wr(MEM_LAYOUT_NMI_A0, 8'h75);
    chk({memoryLayoutCode, nmiEnable}, 5'h0a);
    wr(MEM_LAYOUT_NMI_A1, 8'h83);
    chk({memoryLayoutCode, nmiEnable}, 5'h07);
    rd(MEM_LAYOUT_NMI_A0, 8'hff);
    rd(MEM_LAYOUT_NMI_A1, 8'hff);
    chk({memoryLayoutCode, nmiEnable}, 5'h07);
    wr(16'h03dd, 8'h00);
    rd(16'h0300, 8'hff);
    rd(VIDEO_PAGE_PORT, 8'ha5);
  endtask

  // Watchdog; the whole run needs about a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    test_reset;
    test_video;
    test_floppy;
    test_printer;
    test_status;
    test_joystick;
    test_memory;
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    test_reset;
    @(posedge clk);
    arst_n <= 1'b1;
    rd(VIDEO_PAGE_PORT, 8'h00);
    test_done;
  end
endmodule
